// ===== hw/sdc_driver_ctrl.sv
// Purpose: control and diagnostics of a six-channel load driver
// Assumes: host serial link, sck idle low, data sampled on rising sck
// Notes:   word = 4-bit address over 12 data bits, msb first
`timescale 1ns/1ps
`default_nettype none
module sdc_driver_ctrl #(
    parameter int OL_FILT_US = sdc_pkg::OL_FILT_US,
    parameter int REC_US     = sdc_pkg::REC_US,
    parameter int XC_US      = sdc_pkg::XC_US
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       por_ok_i,
    input  wire logic       sck_i,
    input  wire logic       chip_select_n_i,
    input  wire logic       serial_data_in_i,
    input  wire logic       pwm_in_i,
    input  wire logic [5:0] overcurrent_i,
    input  wire logic [5:0] open_load_i,
    input  wire logic       temp_warn_i,
    input  wire logic       temp_shut_i,
    input  wire logic       temp_cool_i,
    output logic      [5:0] drive_on_o,
    output logic      [5:0] fast_off_o,
    output logic      [5:0] slew_fast_o,
    output logic      [5:0] ol_source_on_o,
    output logic            charge_pump_on_o,
    output logic            standby_o,
    output logic            sdo_o,
    output logic            sdo_oe_n_o
);
    localparam int TW = sdc_pkg::TMR_W;
    localparam int SW = 20;

    // ==========================================================
    // reset release and input synchronisers
    logic [1:0]    rst_q;
    logic          rst_n;
    logic [SW-1:0] sy1;
    logic [SW-1:0] sy2;
    logic          sck_d;
    logic          csn_d;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            sy1   <= 20'h20000;
            sy2   <= 20'h20000;
            sck_d <= 1'b0;
            csn_d <= 1'b1;
        end else begin
            sy1   <= {por_ok_i, sck_i, chip_select_n_i, serial_data_in_i, pwm_in_i,
                      overcurrent_i, open_load_i, temp_warn_i, temp_shut_i, temp_cool_i};
            sy2   <= sy1;
            sck_d <= sy2[18];
            csn_d <= sy2[17];
        end
    end

    logic       por_s;
    logic       sck_s;
    logic       csn_s;
    logic       sdi_s;
    logic       pwm_s;
    logic [5:0] oc_s;
    logic [5:0] ol_s;
    logic       tw_s;
    logic       sd_s;
    logic       cool_s;
    assign {por_s, sck_s, csn_s, sdi_s, pwm_s, oc_s, ol_s, tw_s, sd_s, cool_s} = sy2;

    // ==========================================================
    // 1 us time base
    sdc_tick_if tki ();
    logic [5:0] div;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            div      <= 6'h00;
            tki.tick <= 1'b0;
        end else begin
            tki.tick <= (div == 6'(sdc_pkg::US_CYC - 1));
            div      <= (div == 6'(sdc_pkg::US_CYC - 1)) ? 6'h00 : div + 6'h01;
        end
    end

    // ==========================================================
    // serial link
    logic                     sck_rise;
    logic                     sck_fall;
    logic                     csn_fall;
    logic                     csn_rise;
    logic [15:0]              rx;
    logic [15:0]              tx;
    logic [sdc_pkg::BITS_W-1:0] bit_cnt;
    logic                     wr;
    logic [3:0]               waddr;
    logic [11:0]              wdata;
    logic [5:0]               oc_stat;
    logic [5:0]               ol_stat;
    logic                     tw_stat;
    logic                     sd_stat;

    assign sck_rise = sck_s && !sck_d;
    assign sck_fall = !sck_s && sck_d;
    assign csn_fall = !csn_s && csn_d;
    assign csn_rise = csn_s && !csn_d;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx         <= 16'h0000;
            tx         <= 16'h0000;
            bit_cnt    <= 5'h00;
            wr         <= 1'b0;
            waddr      <= 4'h0;
            wdata      <= 12'h000;
            sdo_o      <= 1'b0;
            sdo_oe_n_o <= 1'b1;
        end else begin
            wr         <= 1'b0;
            sdo_oe_n_o <= csn_s;
            if (csn_fall) begin
                bit_cnt <= 5'h00;
                tx      <= {2'b00, sd_stat, tw_stat, oc_stat, ol_stat};
                sdo_o   <= 1'b0;
            end else if (!csn_s) begin
                if (sck_rise) begin
                    rx <= {rx[14:0], sdi_s};
                    if (bit_cnt != 5'h11) begin
                        bit_cnt <= bit_cnt + 5'h01;
                    end
                end
                if (sck_fall) begin
                    tx    <= {tx[14:0], 1'b0};
                    sdo_o <= tx[14];
                end
            end
            if (csn_rise && bit_cnt == 5'(sdc_pkg::WORD_W)) begin
                wr    <= 1'b1;
                waddr <= rx[15:sdc_pkg::ADDR_LSB];
                wdata <= rx[sdc_pkg::DATA_W-1:0];
            end
        end
    end

    // ==========================================================
    // control words
    logic [11:0] ctrl_w;
    logic [11:0] prot_w;
    logic [11:0] mode_w;
    logic [11:0] aux_w;
    logic        en;
    logic        run;

    assign en  = ctrl_w[sdc_pkg::F_EN];
    assign run = en && por_s;

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_w <= sdc_pkg::CTRL_RST;
            prot_w <= sdc_pkg::PROT_RST;
            mode_w <= sdc_pkg::MODE_RST;
            aux_w  <= sdc_pkg::AUX_RST;
        end else begin
            if (wr && waddr == sdc_pkg::A_CTRL) begin
                ctrl_w <= wdata[sdc_pkg::F_EN] ? wdata : sdc_pkg::CTRL_RST;
            end
            if (!en) begin
                prot_w <= sdc_pkg::PROT_RST;
                mode_w <= sdc_pkg::MODE_RST;
                aux_w  <= sdc_pkg::AUX_RST;
            end else if (wr) begin
                if (waddr == sdc_pkg::A_PROT) prot_w <= wdata;
                if (waddr == sdc_pkg::A_MODE) mode_w <= wdata;
                if (waddr == sdc_pkg::A_AUX)  aux_w  <= wdata;
            end
        end
    end

    logic [5:0] ch_on;
    logic [5:0] rec;
    logic [5:0] led;
    logic [5:0] pwm_sel;
    logic [2:0] bridge;
    logic [5:0] slew_sel;
    logic [5:0] clr_oc;
    logic [5:0] clr_ol;
    logic       clr_tw;
    logic       clr_sd;

    assign ch_on    = ctrl_w[sdc_pkg::F_ON +: 6];
    assign rec      = prot_w[sdc_pkg::F_REC +: 6];
    assign led      = prot_w[sdc_pkg::F_LED +: 6];
    assign pwm_sel  = mode_w[sdc_pkg::F_PWM +: 6];
    assign bridge   = mode_w[sdc_pkg::F_BRIDGE +: 3];
    assign slew_sel = aux_w[sdc_pkg::F_SLEW +: 6];
    assign clr_oc   = (wr && waddr == sdc_pkg::A_CLR) ? wdata[sdc_pkg::F_CLR_OC +: 6] : 6'h00;
    assign clr_ol   = (wr && waddr == sdc_pkg::A_CLR) ? wdata[sdc_pkg::F_CLR_OL +: 6] : 6'h00;
    assign clr_tw   = wr && waddr == sdc_pkg::A_AUX && wdata[sdc_pkg::F_CLR_TW];
    assign clr_sd   = wr && waddr == sdc_pkg::A_AUX && wdata[sdc_pkg::F_CLR_SD];

    // ==========================================================
    // thermal supervision
    logic tw_hit;
    logic sd_hit;
    logic sd_lock;

    sdc_filter #(.LEN(sdc_pkg::TEMP_FILT_US), .CW(TW)) u_tw (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .tk      (tki.snk),
        .cond_i  (tw_s),
        .ok_o    (tw_hit)
    );
    sdc_filter #(.LEN(sdc_pkg::TEMP_FILT_US), .CW(TW)) u_sd (
        .clk_i   (clk_i),
        .rst_n_i (rst_n),
        .tk      (tki.snk),
        .cond_i  (sd_s),
        .ok_o    (sd_hit)
    );

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            tw_stat <= 1'b0;
            sd_stat <= 1'b0;
            sd_lock <= 1'b0;
        end else if (!run) begin
            tw_stat <= 1'b0;
            sd_stat <= 1'b0;
            sd_lock <= sd_lock && !cool_s;
        end else begin
            tw_stat <= tw_hit || (tw_stat && !clr_tw);
            sd_stat <= sd_hit || (sd_stat && !clr_sd);
            if (sd_hit) begin
                sd_lock <= 1'b1;
            end else if (!sd_stat && cool_s) begin
                sd_lock <= 1'b0;
            end
        end
    end

    // ==========================================================
    // channel command and protection
    logic [5:0] cmd;
    logic [5:0] want;
    logic [5:0] oc_off;
    logic [5:0] oc_hit;
    logic [5:0] ol_hit;
    logic [5:0] next_drive;

    assign cmd  = ch_on | ({6{pwm_s}} & (pwm_sel | sdc_pkg::CH2_MASK));
    assign want = cmd & ~oc_off & {6{run && !sd_lock}};

    for (genvar i = 0; i < sdc_pkg::NCH; i++) begin : g_ch
        logic [TW-1:0] rec_cnt;

        sdc_filter #(.LEN(sdc_pkg::OC_FILT_US), .CW(TW)) u_oc (
            .clk_i   (clk_i),
            .rst_n_i (rst_n),
            .tk      (tki.snk),
            .cond_i  (oc_s[i] && drive_on_o[i]),
            .ok_o    (oc_hit[i])
        );
        sdc_filter #(.LEN(OL_FILT_US), .CW(TW)) u_ol (
            .clk_i   (clk_i),
            .rst_n_i (rst_n),
            .tk      (tki.snk),
            .cond_i  (ol_s[i] && !drive_on_o[i] && !led[i] && run),
            .ok_o    (ol_hit[i])
        );

        always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
                oc_stat[i] <= 1'b0;
                ol_stat[i] <= 1'b0;
                oc_off[i]  <= 1'b0;
                rec_cnt    <= '0;
            end else if (!run) begin
                oc_stat[i] <= 1'b0;
                ol_stat[i] <= 1'b0;
                oc_off[i]  <= 1'b0;
                rec_cnt    <= '0;
            end else begin
                oc_stat[i] <= oc_hit[i] || (oc_stat[i] && !clr_oc[i]);
                ol_stat[i] <= ol_hit[i] || (ol_stat[i] && !clr_ol[i]);
                if (oc_hit[i]) begin
                    oc_off[i] <= 1'b1;
                    rec_cnt   <= '0;
                end else if (oc_off[i] && rec[i]) begin
                    if (tki.tick) begin
                        rec_cnt <= rec_cnt + 1'b1;
                    end
                    if (rec_cnt == TW'(REC_US)) begin
                        oc_off[i] <= 1'b0;
                    end
                end else if (oc_off[i] && clr_oc[i]) begin
                    oc_off[i] <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // half bridge interlock
    logic [2:0] xc_busy;

    always_comb begin
        next_drive = want;
        for (int p = 0; p < sdc_pkg::NPAIR; p++) begin
            if (bridge[p]) begin
                next_drive[p]   = want[p] && !drive_on_o[p + 3] && !xc_busy[p];
                next_drive[p+3] = want[p + 3] && !drive_on_o[p] && !xc_busy[p] && !next_drive[p];
            end
        end
    end

    for (genvar p = 0; p < sdc_pkg::NPAIR; p++) begin : g_pair
        logic [TW-1:0] xc_cnt;
        logic          dep_ls;

        always_ff @(posedge clk_i or negedge rst_n) begin
            if (!rst_n) begin
                xc_busy[p]      <= 1'b0;
                xc_cnt          <= '0;
                dep_ls          <= 1'b0;
                fast_off_o[p]   <= 1'b0;
                fast_off_o[p+3] <= 1'b0;
            end else begin
                if (next_drive[p]) fast_off_o[p] <= 1'b0;
                if (next_drive[p + 3]) fast_off_o[p+3] <= 1'b0;
                if (!bridge[p]) begin
                    xc_busy[p] <= 1'b0;
                end else if (xc_busy[p]) begin
                    if (tki.tick) begin
                        xc_cnt <= xc_cnt + 1'b1;
                    end
                    if (xc_cnt == TW'(XC_US)) begin
                        xc_busy[p] <= 1'b0;
                        if (dep_ls) fast_off_o[p+3] <= 1'b1;
                        else fast_off_o[p] <= 1'b1;
                    end
                end else if ((drive_on_o[p] && !next_drive[p]) ||
                             (drive_on_o[p + 3] && !next_drive[p + 3])) begin
                    xc_busy[p] <= 1'b1;
                    xc_cnt     <= '0;
                    dep_ls     <= drive_on_o[p + 3];
                end
            end
        end
    end

    // ==========================================================
    // registered outputs
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            drive_on_o       <= 6'h00;
            slew_fast_o      <= 6'h00;
            ol_source_on_o   <= 6'h00;
            charge_pump_on_o <= 1'b0;
            standby_o        <= 1'b1;
        end else begin
            drive_on_o       <= next_drive;
            slew_fast_o      <= led & slew_sel & ~{bridge, bridge};
            ol_source_on_o   <= {6{run}} & ~led & ~next_drive;
            charge_pump_on_o <= run && ctrl_w[sdc_pkg::F_CP_EN] && !ctrl_w[sdc_pkg::F_CP_DIS];
            standby_o        <= !en;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n);

    a_uv_drive_off: assert property (!por_s |=> drive_on_o == 6'h00)
        else $error("driver on during undervoltage");
    a_cp_gate: assert property (charge_pump_on_o |-> $past(ctrl_w[1] && !ctrl_w[2]))
        else $error("charge pump on without enable");
    a_stby_clear: assert property (!en |=> oc_stat == 6'h00 && ol_stat == 6'h00 && !tw_stat)
        else $error("status kept in standby");
    a_sd_all_off: assert property (sd_lock |=> drive_on_o == 6'h00)
        else $error("driver on during thermal shutdown");
    a_oc_latched: assert property ((oc_off & ~rec) != 6'h00 |=> (drive_on_o & $past(oc_off & ~rec)) == 6'h00)
        else $error("overloaded channel back on without clear");
    a_tw_sticky: assert property (tw_stat && run && !clr_tw |=> tw_stat)
        else $error("warning flag lost");
    a_sdo_tri: assert property (csn_s |=> sdo_oe_n_o)
        else $error("data output driven while deselected");
    a_led_no_src: assert property (led != 6'h00 |=> (ol_source_on_o & $past(led)) == 6'h00)
        else $error("test source on in led mode");
    a_apply_cnt: assert property (wr |-> $past(bit_cnt) == 5'h10 && $past(csn_rise))
        else $error("word applied without sixteen clocks");
    a_xc_block: assert property (xc_busy[0] |=> !drive_on_o[0] || !drive_on_o[3])
        else $error("both drivers of a half bridge on");
endmodule
`default_nettype wire

// ===== hw/sdc_filter.sv
// Purpose: persistence filter, condition must hold LEN ticks
// Assumes: cond_i is synchronous to clk_i
// Notes:   any gap in the condition restarts the count
`timescale 1ns/1ps
`default_nettype none
module sdc_filter #(
    parameter int LEN = 32,
    parameter int CW  = 14
) (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    sdc_tick_if.snk   tk,
    input  wire logic cond_i,
    output logic      ok_o
);
    logic [CW-1:0] cnt;

    // ==========================================================
    // tick counter
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt <= '0;
        end else if (!cond_i) begin
            cnt <= '0;
        end else if (tk.tick && cnt != CW'(LEN)) begin
            cnt <= cnt + 1'b1;
        end
    end

    assign ok_o = cond_i && (cnt == CW'(LEN));

    // ==========================================================
    // checks
    a_filt_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        $rose(ok_o) |-> $past(cond_i) && $past(cnt) == CW'(LEN - 1))
        else $error("filter passed before its full hold time");
endmodule
`default_nettype wire

// ===== hw/sdc_pkg.sv
// Purpose: shared constants of the six-channel driver control block
// Assumes: 50 MHz system clock, 16-bit serial control word
// Notes:   times are in microseconds, counted on a 1 us tick
package sdc_pkg;
    // ==========================================================
    // clocking and timing
    localparam int CLK_HZ       = 50_000_000;
    localparam int US_CYC       = CLK_HZ / 1_000_000;
    localparam int OC_FILT_US   = 32;
    localparam int TEMP_FILT_US = 32;
    localparam int OL_FILT_US   = 3000;
    localparam int REC_US       = 100;
    localparam int XC_US        = 200;
    localparam int TMR_W        = 14;
    // ==========================================================
    // channels and serial word
    localparam int NCH          = 6;
    localparam int NPAIR        = 3;
    localparam int WORD_W       = 16;
    localparam int DATA_W       = 12;
    localparam int ADDR_LSB     = 12;
    localparam int BITS_W       = 5;
    localparam logic [5:0] CH2_MASK = 6'h02;
    // ==========================================================
    // word addresses
    localparam logic [3:0] A_CTRL = 4'h0;
    localparam logic [3:0] A_PROT = 4'h1;
    localparam logic [3:0] A_MODE = 4'h2;
    localparam logic [3:0] A_AUX  = 4'h3;
    localparam logic [3:0] A_CLR  = 4'h4;
    // ==========================================================
    // field positions
    localparam int F_EN     = 0;
    localparam int F_CP_EN  = 1;
    localparam int F_CP_DIS = 2;
    localparam int F_ON     = 3;
    localparam int F_REC    = 0;
    localparam int F_LED    = 6;
    localparam int F_PWM    = 0;
    localparam int F_BRIDGE = 6;
    localparam int F_SLEW   = 0;
    localparam int F_CLR_TW = 6;
    localparam int F_CLR_SD = 7;
    localparam int F_CLR_OC = 0;
    localparam int F_CLR_OL = 6;
    // ==========================================================
    // reset values
    localparam logic [11:0] CTRL_RST = 12'h000;
    localparam logic [11:0] PROT_RST = 12'h000;
    localparam logic [11:0] MODE_RST = 12'h000;
    localparam logic [11:0] AUX_RST  = 12'h000;
endpackage

// ===== hw/sdc_tick_if.sv
// Purpose: carries the 1 us time base to the filter instances
// Assumes: single clock domain
// Notes:   one-cycle pulse
`timescale 1ns/1ps
`default_nettype none
interface sdc_tick_if;
    logic tick;
    modport src (output tick);
    modport snk (input tick);
endinterface
`default_nettype wire

// ===== test/sdc_driver_ctrl_tb.sv
// Purpose: self-checking bench of the driver control block
// Assumes: open-load, recovery and cross-conduction timers cut to 5 us; overcurrent and thermal filters stay at 32 us
// Notes:   status word {00, sd, tw, oc, ol}
`timescale 1ns/1ps
`default_nettype none
module sdc_driver_ctrl_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        por_ok = 1'b1;
    logic        pwm = 1'b0;
    logic        tw = 1'b0;
    logic        ts = 1'b0;
    logic        tc = 1'b0;
    logic [5:0]  oc = 6'h00;
    logic [5:0]  ol = 6'h00;
    logic [5:0]  drv, sf, src, fo;
    logic        sck, chip_select_n, sdi, cp, stby, sdo, oe_n;
    logic [15:0] rx;
    int          err_total = 0;
    int          comparisons = 0;
    // ==========================================================
    // harness
    always #10 clk = ~clk;
    sdc_host_model u_host (.clk_i(clk), .sdo_i(sdo), .sck_o(sck), .csn_o(chip_select_n), .sdi_o(sdi));
    sdc_driver_ctrl #(.OL_FILT_US(5), .REC_US(5), .XC_US(5)) u_dut (
        .clk_i(clk), .rst_n_i(rst_n), .por_ok_i(por_ok), .sck_i(sck), .chip_select_n_i(chip_select_n),
        .serial_data_in_i(sdi), .pwm_in_i(pwm), .overcurrent_i(oc), .open_load_i(ol), .temp_warn_i(tw),
        .temp_shut_i(ts), .temp_cool_i(tc), .drive_on_o(drv), .fast_off_o(fo), .slew_fast_o(sf),
        .ol_source_on_o(src), .charge_pump_on_o(cp), .standby_o(stby), .sdo_o(sdo), .sdo_oe_n_o(oe_n));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [15:0] w);
        u_host.xfer(w, 16, rx);
    endtask
    function automatic logic [15:0] ctl(input logic [5:0] on, input logic [2:0] low);
        return {sdc_pkg::A_CTRL, 3'h0, on, low};
    endfunction
    task automatic wait_drv(input int ch, input logic v, input int lim);
        int n;
        n = 0;
        while (drv[ch] !== v && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk({15'h0, drv[ch]}, {15'h0, v});
        if (drv[ch] !== v)
            summarize();
    endtask
    // ==========================================================
    // scenarios
    task automatic t_basic();
        chk(stby, 1'b1);
        chk(oe_n, 1'b1);
        wr(ctl(6'h00, 3'b011));
        chk(cp, 1'b1);
        wr(ctl(6'h00, 3'b111));
        chk(cp, 1'b0);
        u_host.xfer(ctl(6'h3f, 3'b001), 15, rx);
        chk(drv, 6'h00);
        @(posedge clk) pwm <= 1'b1;
        repeat (8) @(posedge clk);
        chk(drv, 6'h02);
        wr({sdc_pkg::A_MODE, 12'h001});
        chk(drv, 6'h03);
        wr({sdc_pkg::A_MODE, 12'h000});
        @(posedge clk) pwm <= 1'b0;
        wr(ctl(6'h03, 3'b001));
        chk(drv, 6'h03);
        $display("test basic done");
    endtask
    task automatic t_oc();
        @(posedge clk) oc <= 6'h01;
        repeat (1000) @(posedge clk);
        chk(drv, 6'h03);
        wait_drv(0, 1'b0, 2500);
        repeat (1000) @(posedge clk);
        chk(drv, 6'h02);
        wr(ctl(6'h03, 3'b001));
        chk(rx, 16'h0040);
        @(posedge clk) oc <= 6'h00;
        wr({sdc_pkg::A_CLR, 12'h001});
        wait_drv(0, 1'b1, 50);
        wr({sdc_pkg::A_PROT, 12'h002});
        @(posedge clk) oc <= 6'h02;
        wait_drv(1, 1'b0, 2500);
        wait_drv(1, 1'b1, 400);
        @(posedge clk) oc <= 6'h00;
        wr({sdc_pkg::A_CLR, 12'h002});
        $display("test overcurrent done");
    endtask
    task automatic t_temp();
        @(posedge clk) {tw, ts} <= 2'b11;
        repeat (2000) @(posedge clk);
        @(posedge clk) {tw, ts} <= 2'b00;
        chk(drv, 6'h00);
        wr(ctl(6'h03, 3'b001));
        chk(rx, 16'h3000);
        @(posedge clk) tc <= 1'b1;
        repeat (20) @(posedge clk);
        chk(drv, 6'h00);
        wr({sdc_pkg::A_AUX, 12'h0c0});
        chk(drv, 6'h03);
        $display("test thermal done");
    endtask
    task automatic t_diag();
        chk(src, 6'h3c);
        @(posedge clk) ol <= 6'h20;
        repeat (600) @(posedge clk);
        chk(drv, 6'h03);
        wr(ctl(6'h03, 3'b001));
        chk(rx, 16'h0020);
        @(posedge clk) ol <= 6'h00;
        wr({sdc_pkg::A_CLR, 12'h800});
        wr({sdc_pkg::A_PROT, 12'h800});
        chk(src, 6'h1c);
        wr({sdc_pkg::A_AUX, 12'h020});
        chk(sf, 6'h20);
        $display("test diagnostics done");
    endtask
    task automatic t_standby();
        wr(ctl(6'h03, 3'b000));
        chk({stby, drv}, 7'h40);
        wr(ctl(6'h03, 3'b001));
        chk(sf, 6'h00);
        @(posedge clk) por_ok <= 1'b0;
        repeat (8) @(posedge clk);
        chk(drv, 6'h00);
        @(posedge clk) por_ok <= 1'b1;
        $display("test standby done");
    endtask
    task automatic t_bridge();
        @(posedge clk) pwm <= 1'b0;
        wr({sdc_pkg::A_MODE, 12'h0c0});
        wr(ctl(6'h08, 3'b001));
        chk(drv, 6'h00);
        wait_drv(3, 1'b1, 400);
        chk(fo, 6'h03);
        chk(sf, 6'h00);
        wr(ctl(6'h01, 3'b001));
        chk(drv, 6'h00);
        wait_drv(0, 1'b1, 400);
        chk(fo, 6'h0a);
        $display("test bridge done");
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        t_basic();
        t_oc();
        t_temp();
        t_diag();
        t_standby();
        t_bridge();
        summarize();
    end
endmodule
`default_nettype wire

// ===== test/sdc_host_model.sv
// Purpose: host side of the serial link
// Assumes: sck idle low, 4 clk high and 4 clk low
// Notes:   data line inverts while deselected
`timescale 1ns/1ps
`default_nettype none
module sdc_host_model (
    input  wire logic clk_i,
    input  wire logic sdo_i,
    output logic      sck_o,
    output logic      csn_o,
    output logic      sdi_o
);
    // ==========================================================
    // one word, nb bits, msb first
    initial begin
        sck_o = 1'b0;
        csn_o = 1'b1;
        sdi_o = 1'b0;
    end
    task automatic xfer(input logic [15:0] w, input int nb, output logic [15:0] rx);
        rx = 16'h0000;
        @(posedge clk_i) csn_o <= 1'b0;
        repeat (4) @(posedge clk_i);
        for (int i = 15; i > 15 - nb; i--) begin
            sdi_o <= w[i];
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b1;
            rx = {rx[14:0], sdo_i};
            repeat (4) @(posedge clk_i);
            sck_o <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        csn_o <= 1'b1;
        sdi_o <= ~sdi_o;
        repeat (10) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire
